// ### rtl/lpmc_device.sv
// Purpose: Low-power mode selection, module-stop bits and wake handling
// Assumes: Host end drives requests held until reg_ack; same-clock inputs
// Notes: Resource controls are registered one cycle after the mode
//
// What this block does
// RULE1: Reset: run, all modules stopped but DMA.
// RULE2: Standby-select picks software standby on wait.
// RULE3: Standby-select stays 1 after interrupt release.
// RULE4: Osc-stop-detect enable overrides standby-select.
// RULE5: Clock-stop enable plus conditions gives clock stop.
// RULE6: Both bits zero: wait enters sleep.
// RULE7: Module-stop bit 1 stops, 0 releases.
// RULE8: Spare bits written 1 before clock stop.
// RULE9: Standby reserved bits: b14 one, rest zero.
// RULE10: Module-stop reserved bits read as one.
// RULE11: Writes need write-protect release set first.
// RULE12: Interrupt release returns to program execution.
// RULE13: Resets put device in reset state.
// RULE14: Clock-stop wake sources include timer, osc-stop.
// RULE15: Standby wakes exclude timer and osc-stop.
// RULE16: Stopped-retained: CPU always, flash/RAM outside sleep.
// RULE17: Clock stop keeps timers per their stop bits.
// RULE18: Standby with soft cut stops voltage monitors.
// RULE19: Running timer or RTC keeps its pins live.
// RULE20: Watchdog stop per auto-start option or register.
// RULE21: Mode chosen from bits at wait completion.
`timescale 1ns/100ps
module lpmc_device
	import lpmc_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Chip reset, any source
	lpmc_link_if.dev link, // Host-side link
	input wire logic [15:0] wake_src, // Interrupt requests, one per source
	input wire logic osc_stop_detect_enable, // Oscillation-stop detect enabled
	input wire logic flash_osc_soft_cut, // Flash oscillator software cut
	input wire logic wdog_autostart, // Watchdog in auto-start mode
	input wire logic wdog_autostart_sleep_stop, // Option stop bit for auto-start
	input wire logic wdog_sleep_count_stop, // Count-stop register bit
	input wire logic subclock_osc_enable, // RTC sub-clock oscillator enabled
	output logic [31:0] module_stop, // Effective module-stop vector
	output logic cpu_stop, // CPU stopped, registers retained
	output logic ram_stop, // RAM stopped, contents retained
	output logic flash_stop, // Flash stopped, contents retained
	output logic periph_clk_stop, // Peripheral clocks gated
	output logic osc_stop, // Main and on-chip oscillators stopped
	output logic [1:0] timer_run, // 8-bit timer unit 1, unit 0 running
	output logic timer_pins_live, // Timer pins keep operating
	output logic rtc_pins_live, // RTC pins keep operating
	output logic io_hold, // Other I/O pins held
	output logic lvd_stop, // Voltage monitors stopped
	output logic por_low_power, // Power-on reset low-power function on
	output logic wdog_count_stop // Watchdog counting stopped
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic standby_select;
	logic [31:0] mstpa;
	logic [31:0] mstpa_view;
	logic [15:0] stby_view;
	logic wr_ok;
	lpmc_mode_e mode;
	lpmc_mode_e next_mode;
	logic wake_hit;
	logic spares_set;
	logic low_power;

	assign mstpa_view = (mstpa & LPMC_MSTPA_RW_MASK) | ~LPMC_MSTPA_RW_MASK; // RULE10
	assign stby_view = {standby_select, 15'h0} | LPMC_STBY_RESV_ONES; // RULE9
	// Protect release gates the store; the ack still comes so the host never hangs
	assign wr_ok = link.reg_req && !link.reg_ack && link.reg_wr && link.prot_release; // RULE11

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_select <= LPMC_STBY_SEL_RESET; // RULE13
		end else if (wr_ok && link.reg_sel == LPMC_SEL_STBY) begin
			// Only a write or reset clears it; wake-up leaves it alone
			standby_select <= link.reg_wdata[LPMC_STBY_SEL_BIT]; // RULE3
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mstpa <= LPMC_MSTPA_RESET; // RULE1
		end else if (wr_ok && link.reg_sel == LPMC_SEL_MSTPA) begin
			mstpa <= (link.reg_wdata & LPMC_MSTPA_RW_MASK) | ~LPMC_MSTPA_RW_MASK; // RULE7 RULE8
		end
	end

	// ------------------------------------------------------------
	// Register port answer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.reg_ack <= 1'b0;
			link.reg_rdata <= 32'h00000000;
		end else begin
			link.reg_ack <= link.reg_req && !link.reg_ack;
			if (link.reg_req && !link.reg_ack) begin
				link.reg_rdata <= (link.reg_sel == LPMC_SEL_STBY) ?
					{16'h0000, stby_view} : mstpa_view; // RULE9 RULE10
			end
		end
	end

	// ------------------------------------------------------------
	// Mode selection and release
	// ------------------------------------------------------------
	assign spares_set = (mstpa & LPMC_SPARE_MASK) == LPMC_SPARE_MASK; // RULE5

	always_comb begin
		next_mode = mode;
		wake_hit = 1'b0;
		case (mode)
			LPMC_RUN: begin
				if (link.wait_exec) begin // RULE21
					if (standby_select && !osc_stop_detect_enable) begin // RULE2 RULE4
						next_mode = LPMC_SSTBY;
					end else if (mstpa[LPMC_ALL_CLOCK_STOP_ENABLE_BIT] && spares_set) begin // RULE5
						next_mode = LPMC_ACS;
					end else begin
						next_mode = LPMC_SLEEP; // RULE6
					end
				end
			end
			LPMC_SLEEP: begin
				wake_hit = |wake_src; // RULE12
			end
			LPMC_ACS: begin
				wake_hit = |(wake_src & LPMC_WAKE_ACS_MASK); // RULE14
			end
			LPMC_SSTBY: begin
				wake_hit = |(wake_src & LPMC_WAKE_SSTBY_MASK); // RULE15
			end
			default: begin
				next_mode = LPMC_RUN;
			end
		endcase
		if (wake_hit) begin
			next_mode = LPMC_RUN; // RULE12
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= LPMC_RUN; // RULE1 RULE13
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.mode <= LPMC_RUN;
			link.wake_pulse <= 1'b0;
		end else begin
			link.mode <= next_mode;
			link.wake_pulse <= wake_hit; // RULE12
		end
	end

	// ------------------------------------------------------------
	// Resource controls
	// ------------------------------------------------------------
	assign low_power = (mode != LPMC_RUN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_stop <= LPMC_MSTPA_RESET; // RULE1
			cpu_stop <= 1'b0;
			ram_stop <= 1'b0;
			flash_stop <= 1'b0;
			periph_clk_stop <= 1'b0;
			osc_stop <= 1'b0;
			io_hold <= 1'b0;
		end else begin
			module_stop <= mstpa_view; // RULE7
			cpu_stop <= low_power; // RULE16
			ram_stop <= (mode == LPMC_ACS) || (mode == LPMC_SSTBY); // RULE16
			flash_stop <= (mode == LPMC_ACS) || (mode == LPMC_SSTBY); // RULE16
			periph_clk_stop <= (mode == LPMC_ACS) || (mode == LPMC_SSTBY);
			osc_stop <= (mode == LPMC_SSTBY);
			io_hold <= (mode == LPMC_ACS) || (mode == LPMC_SSTBY);
		end
	end

	// Timers survive clock stop only by their own stop bits; standby halts them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_run <= 2'b00;
			timer_pins_live <= 1'b0;
			rtc_pins_live <= 1'b0;
		end else begin
			if (mode == LPMC_SSTBY) begin
				timer_run <= 2'b00;
			end else begin
				timer_run <= ~{mstpa[LPMC_TMR1_BIT], mstpa[LPMC_TMR0_BIT]}; // RULE17
			end
			timer_pins_live <= (mode != LPMC_SSTBY) &&
				!(mstpa[LPMC_TMR1_BIT] && mstpa[LPMC_TMR0_BIT]); // RULE19
			rtc_pins_live <= subclock_osc_enable; // RULE19
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvd_stop <= 1'b0;
			por_low_power <= 1'b0;
			wdog_count_stop <= 1'b0;
		end else begin
			lvd_stop <= (mode == LPMC_SSTBY) && flash_osc_soft_cut; // RULE18
			por_low_power <= (mode == LPMC_SSTBY) && flash_osc_soft_cut; // RULE18
			wdog_count_stop <= low_power && (wdog_autostart ?
				wdog_autostart_sleep_stop : wdog_sleep_count_stop); // RULE20
		end
	end
endmodule : lpmc_device

// ### rtl/lpmc_pkg.sv
// Purpose: Shared constants and types for the low-power mode controller
// Assumes: 32-bit link data, one clock domain
// Notes: Used by both link ends and the interface
package lpmc_pkg;
	// ------------------------------------------------------------
	// Device register map
	// ------------------------------------------------------------
	localparam logic [31:0] LPMC_STBY_ADDR = 32'h0008000C;
	localparam logic [31:0] LPMC_MSTPA_ADDR = 32'h00080010;
	localparam logic LPMC_SEL_STBY = 1'b0;
	localparam logic LPMC_SEL_MSTPA = 1'b1;
	localparam int LPMC_STBY_SEL_BIT = 15;
	localparam int LPMC_STBY_ONE_BIT = 14;
	localparam int LPMC_ALL_CLOCK_STOP_ENABLE_BIT = 31;
	localparam int LPMC_SPARE29_BIT = 29;
	localparam int LPMC_DMA_BIT = 28;
	localparam int LPMC_SPARE27_BIT = 27;
	localparam int LPMC_SPARE24_BIT = 24;
	localparam int LPMC_CONV_BIT = 17;
	localparam int LPMC_CMT0_BIT = 15;
	localparam int LPMC_CMT1_BIT = 14;
	localparam int LPMC_MTU_BIT = 9;
	localparam int LPMC_TMR0_BIT = 5;
	localparam int LPMC_TMR1_BIT = 4;
	localparam logic [31:0] LPMC_MSTPA_RESET = 32'h46FFFFFF;
	localparam logic [31:0] LPMC_MSTPA_RW_MASK = 32'hB902C230;
	localparam logic [31:0] LPMC_SPARE_MASK = 32'h29000000;
	localparam logic [15:0] LPMC_STBY_RESV_ONES = 16'h4000;
	localparam logic LPMC_STBY_SEL_RESET = 1'b0;
	// ------------------------------------------------------------
	// Wake source vector positions
	// ------------------------------------------------------------
	localparam int LPMC_WAKE_W = 16;
	localparam int LPMC_WK_NMI = 0;
	localparam int LPMC_WK_IRQ0 = 1;
	localparam int LPMC_WK_TMR = 9;
	localparam int LPMC_WK_RTC_ALM = 10;
	localparam int LPMC_WK_RTC_PRD = 11;
	localparam int LPMC_WK_WDOG = 12;
	localparam int LPMC_WK_LVD1 = 13;
	localparam int LPMC_WK_LVD2 = 14;
	localparam int LPMC_WK_OSC = 15;
	localparam logic [15:0] LPMC_WAKE_ACS_MASK = 16'hFFFF;
	localparam logic [15:0] LPMC_WAKE_SSTBY_MASK = 16'h7DFF;
	// ------------------------------------------------------------
	// Host (controller) APB register map
	// ------------------------------------------------------------
	localparam logic [7:0] LPMC_H_CMD = 8'h00;
	localparam logic [7:0] LPMC_H_WDATA = 8'h04;
	localparam logic [7:0] LPMC_H_RDATA = 8'h08;
	localparam logic [7:0] LPMC_H_STATUS = 8'h0C;
	localparam logic [1:0] LPMC_OP_READ = 2'h0;
	localparam logic [1:0] LPMC_OP_WRITE = 2'h1;
	localparam logic [1:0] LPMC_OP_WAIT = 2'h2;
	localparam int LPMC_CMD_SEL_BIT = 2;
	localparam int LPMC_ST_WAKE_BIT = 3;
	localparam logic [31:0] LPMC_WDATA_RESET = 32'h00000000;

	typedef enum logic [1:0] {LPMC_RUN, LPMC_SLEEP, LPMC_ACS, LPMC_SSTBY} lpmc_mode_e;
endpackage : lpmc_pkg

// ### rtl/lpmc_link_if.sv
// Purpose: Link between the host side and the low-power mode device
// Assumes: Single clock, request held until acknowledged
// Notes: No clocking block; the bench joins both ends here
`timescale 1ns/100ps
interface lpmc_link_if (input wire logic pclk);
	import lpmc_pkg::*;
	logic reg_req;
	logic reg_wr;
	logic reg_sel;
	logic [31:0] reg_wdata;
	logic reg_ack;
	logic [31:0] reg_rdata;
	logic prot_release;
	logic wait_exec;
	lpmc_mode_e mode;
	logic wake_pulse;

	modport dev (input reg_req, reg_wr, reg_sel, reg_wdata, prot_release, wait_exec,
		output reg_ack, reg_rdata, mode, wake_pulse);
	modport host (output reg_req, reg_wr, reg_sel, reg_wdata, prot_release, wait_exec,
		input reg_ack, reg_rdata, mode, wake_pulse);
endinterface : lpmc_link_if

// ### rtl/lpmc_host.sv
// Purpose: Host end: turns APB commands into protected register accesses
// Assumes: Device acks each held request; APB master per protocol
// Notes: pready comes one cycle into the access phase
`timescale 1ns/100ps
module lpmc_host
	import lpmc_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	lpmc_link_if.host link // Device link
);
	typedef enum logic [2:0] {H_IDLE, H_UNLOCK, H_ACCESS, H_LOCK} lpmc_hstate_e;
	lpmc_hstate_e state;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wake_seen;
	logic op_wr;
	logic op_sel;
	logic apb_go;
	logic cmd_go;
	logic mapped;

	assign apb_go = psel && penable && !pready;
	assign cmd_go = apb_go && pwrite && paddr == LPMC_H_CMD && state == H_IDLE;
	assign mapped = paddr == LPMC_H_CMD || paddr == LPMC_H_WDATA ||
		paddr == LPMC_H_RDATA || paddr == LPMC_H_STATUS;

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= apb_go;
			pslverr <= apb_go && !mapped;
			if (apb_go && !pwrite) begin
				case (paddr)
					LPMC_H_WDATA: prdata <= wdata;
					LPMC_H_RDATA: prdata <= rdata;
					LPMC_H_STATUS: prdata <= {28'h0000000, wake_seen, link.mode,
						state != H_IDLE};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata <= LPMC_WDATA_RESET;
		end else if (apb_go && pwrite && paddr == LPMC_H_WDATA) begin
			wdata <= pwdata;
		end
	end

	// Set wins over the write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_seen <= 1'b0;
		end else if (link.wake_pulse) begin
			wake_seen <= 1'b1;
		end else if (apb_go && pwrite && paddr == LPMC_H_STATUS && pwdata[LPMC_ST_WAKE_BIT]) begin
			wake_seen <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= H_IDLE;
			op_wr <= 1'b0;
			op_sel <= 1'b0;
			rdata <= 32'h00000000;
			link.reg_req <= 1'b0;
			link.reg_wr <= 1'b0;
			link.reg_sel <= 1'b0;
			link.reg_wdata <= 32'h00000000;
			link.prot_release <= 1'b0;
			link.wait_exec <= 1'b0;
		end else begin
			link.wait_exec <= 1'b0;
			case (state)
				H_IDLE: begin
					if (cmd_go && pwdata[1:0] == LPMC_OP_WAIT) begin
						link.wait_exec <= (link.mode == LPMC_RUN);
					end else if (cmd_go && pwdata[1:0] == LPMC_OP_WRITE) begin
						op_wr <= 1'b1;
						op_sel <= pwdata[LPMC_CMD_SEL_BIT];
						link.prot_release <= 1'b1; // RULE11
						state <= H_UNLOCK;
					end else if (cmd_go && pwdata[1:0] == LPMC_OP_READ) begin
						op_wr <= 1'b0;
						op_sel <= pwdata[LPMC_CMD_SEL_BIT];
						state <= H_UNLOCK;
					end
				end
				H_UNLOCK: begin
					link.reg_req <= 1'b1;
					link.reg_wr <= op_wr;
					link.reg_sel <= op_sel;
					if (op_sel == LPMC_SEL_STBY) begin
						link.reg_wdata <= {16'h0000, wdata[LPMC_STBY_SEL_BIT], 15'h0} |
							{16'h0000, LPMC_STBY_RESV_ONES}; // RULE9
					end else if (wdata[LPMC_ALL_CLOCK_STOP_ENABLE_BIT]) begin
						link.reg_wdata <= wdata | ~LPMC_MSTPA_RW_MASK | LPMC_SPARE_MASK; // RULE8
					end else begin
						link.reg_wdata <= wdata | ~LPMC_MSTPA_RW_MASK; // RULE10
					end
					state <= H_ACCESS;
				end
				H_ACCESS: begin
					if (link.reg_ack) begin
						link.reg_req <= 1'b0;
						rdata <= link.reg_rdata;
						state <= H_LOCK;
					end
				end
				H_LOCK: begin
					link.prot_release <= 1'b0;
					state <= H_IDLE;
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end
endmodule : lpmc_host

// ### verif/lpmc_link_monitor.sv
// Purpose: Link handshake and mode checks
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees the link signals only
`timescale 1ns/100ps
module lpmc_link_monitor
	import lpmc_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic reg_req, // Request
	input wire logic reg_wr, // Write
	input wire logic reg_sel, // Register select
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_ack, // Ack
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic prot_release, // Write enable
	input wire logic wait_exec, // Wait pulse
	input wire lpmc_mode_e mode, // Mode
	input wire logic wake_pulse // Wake pulse
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ack_next_a: assert property (reg_req && !reg_ack |=> reg_ack)
		else $error("link ack missing");
	ack_pulse_a: assert property (reg_ack |=> !reg_ack)
		else $error("link ack too long");
	prot_write_a: assert property (reg_req && reg_wr |-> prot_release)
		else $error("write without release");
	stby_resv_a: assert property (reg_ack && !reg_wr && reg_sel == LPMC_SEL_STBY
		|-> reg_rdata[14:0] == 15'h4000) else $error("standby reserved bits");
	mstp_resv_a: assert property (reg_ack && !reg_wr && reg_sel == LPMC_SEL_MSTPA
		|-> &(reg_rdata | LPMC_MSTPA_RW_MASK)) else $error("module stop reserved bits");
	wait_leave_a: assert property (wait_exec && mode == LPMC_RUN |=> mode != LPMC_RUN)
		else $error("wait ignored");
	run_stays_a: assert property (mode == LPMC_RUN && !wait_exec |=> mode == LPMC_RUN)
		else $error("mode left run without wait");
	wake_run_a: assert property (wake_pulse |-> mode == LPMC_RUN && $past(mode) != LPMC_RUN)
		else $error("wake without return");
	low_exit_a: assert property ($past(mode) != LPMC_RUN && mode != $past(mode)
		|-> wake_pulse) else $error("low mode left silently");
endmodule : lpmc_link_monitor

// ### verif/low_power_mode_controller_tb.sv
// Purpose: Self-checking bench for host and device joined by the link
// Assumes: APB master per protocol, one clock
// Notes: Expected reads queued by the driver, compared by a watcher
`timescale 1ns/100ps
module low_power_mode_controller_tb
	import lpmc_pkg::*;
;
	typedef struct {logic rd; logic err; logic [31:0] exp; logic [31:0] mask;} lpmc_note_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, module_stop, q, r, e;
	logic cpu_stop, ram_stop, flash_stop, periph_clk_stop, osc_stop, tpl, rpl, io_hold;
	logic [1:0] timer_run;
	logic lvd_stop, por_low_power, wdog_count_stop;
	logic [15:0] wake_src;
	logic osc_det, soft_cut, wd_auto, wd_auto_stop, wd_cnt_stop, sub_en;
	int n_errors, comparisons;
	lpmc_note_s notes[$];

	lpmc_link_if link (.pclk(pclk));
	lpmc_host u_lpmc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	lpmc_device u_lpmc_device (.pclk(pclk), .presetn(presetn), .link(link),
		.wake_src(wake_src), .osc_stop_detect_enable(osc_det), .flash_osc_soft_cut(soft_cut),
		.wdog_autostart(wd_auto), .wdog_autostart_sleep_stop(wd_auto_stop),
		.wdog_sleep_count_stop(wd_cnt_stop), .subclock_osc_enable(sub_en),
		.module_stop(module_stop), .cpu_stop(cpu_stop), .ram_stop(ram_stop),
		.flash_stop(flash_stop), .periph_clk_stop(periph_clk_stop), .osc_stop(osc_stop),
		.timer_run(timer_run), .timer_pins_live(tpl), .rtc_pins_live(rpl), .io_hold(io_hold),
		.lvd_stop(lvd_stop), .por_low_power(por_low_power), .wdog_count_stop(wdog_count_stop));
	lpmc_link_monitor u_lpmc_link_monitor (.pclk(pclk), .presetn(presetn),
		.reg_req(link.reg_req), .reg_wr(link.reg_wr), .reg_sel(link.reg_sel),
		.reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata),
		.prot_release(link.prot_release), .wait_exec(link.wait_exec), .mode(link.mode),
		.wake_pulse(link.wake_pulse));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// APB master and link helpers
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic [31:0] mask, input logic err);
		notes.push_back('{!wr, err, exp, mask});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle limit; only the watchdog may end a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic link_op(input logic [1:0] op, input logic sel, input logic [31:0] d);
		apb(1'b1, LPMC_H_WDATA, d, 32'h0, 32'h0, 1'b0);
		apb(1'b1, LPMC_H_CMD, 32'(op) | (32'(sel) << LPMC_CMD_SEL_BIT), 32'h0, 32'h0, 1'b0);
		// A wait command never leaves the host idle, so busy is never set and wait commands skip the poll
		if (op != LPMC_OP_WAIT) begin
			do begin
				apb(1'b0, LPMC_H_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
			end while (q[0] !== 1'b0);
		end
	endtask : link_op

	task automatic link_rd(input logic sel, input logic [31:0] exp, input logic [31:0] mask);
		link_op(LPMC_OP_READ, sel, 32'h0);
		apb(1'b0, LPMC_H_RDATA, 32'h0, exp, mask, 1'b0);
	endtask : link_rd

	task automatic await_mode(input lpmc_mode_e m);
		int n;
		n = 0;
		while (link.mode !== m && n < 50) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		check("mode", 32'(link.mode), 32'(m));
	endtask : await_mode

	task automatic wake(input int b, input lpmc_mode_e m);
		wake_src[b] <= 1'b1;
		repeat (8) @(posedge pclk);
		check("wake mode", 32'(link.mode), 32'(m));
		wake_src[b] <= 1'b0;
		@(posedge pclk);
	endtask : wake

	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && notes.size() > 0) begin
			lpmc_note_s nt;
			nt = notes.pop_front();
			check("pslverr", 32'(pslverr), 32'(nt.err));
			if (nt.rd) check("prdata", prdata & nt.mask, nt.exp);
		end
	end

	initial begin
		#100000;
		n_errors++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn, wake_src} = '0;
		{osc_det, soft_cut} = 2'b00;
		void'($urandom(33782));
		{wd_auto, wd_auto_stop, wd_cnt_stop, sub_en} = 4'($urandom);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("module_stop", module_stop, LPMC_MSTPA_RESET);
		check("mode", 32'(link.mode), 32'(LPMC_RUN));
		link_rd(LPMC_SEL_STBY, 32'h4000, 32'hFFFF);
		link_rd(LPMC_SEL_MSTPA, LPMC_MSTPA_RESET, 32'hFFFFFFFF);
		$display("test reset done");
		r = $urandom & 32'h7FFFFFFF;
		e = (r & LPMC_MSTPA_RW_MASK) | ~LPMC_MSTPA_RW_MASK;
		link_op(LPMC_OP_WRITE, LPMC_SEL_MSTPA, r);
		link_rd(LPMC_SEL_MSTPA, e, 32'hFFFFFFFF);
		check("module_stop", module_stop, e);
		apb(1'b1, 8'h10, 32'h0, 32'h0, 32'h0, 1'b1);
		$display("test module stop done");
		link_op(LPMC_OP_WAIT, 1'b0, 32'h0);
		await_mode(LPMC_SLEEP);
		check("sleep stops", 32'({cpu_stop, flash_stop, ram_stop}), 32'h4);
		check("sleep gates", 32'({periph_clk_stop, osc_stop, io_hold}), 32'h0);
		check("wdog", 32'(wdog_count_stop), 32'(wd_auto ? wd_auto_stop : wd_cnt_stop));
		apb(1'b0, LPMC_H_STATUS, 32'h0, 32'h2, 32'hF, 1'b0);
		wake(LPMC_WK_TMR, LPMC_RUN);
		apb(1'b0, LPMC_H_STATUS, 32'h0, 32'h8, 32'hF, 1'b0);
		apb(1'b1, LPMC_H_STATUS, 32'h8, 32'h0, 32'h0, 1'b0);
		apb(1'b0, LPMC_H_STATUS, 32'h0, 32'h0, 32'hF, 1'b0);
		$display("test sleep done");
		soft_cut <= 1'b1;
		link_op(LPMC_OP_WRITE, LPMC_SEL_STBY, 32'hC000);
		link_op(LPMC_OP_WAIT, 1'b0, 32'h0);
		await_mode(LPMC_SSTBY);
		check("standby", 32'({lvd_stop, por_low_power, ram_stop, flash_stop}), 32'hF);
		check("standby held", 32'({osc_stop, io_hold, tpl, timer_run}), 32'h18);
		wake(LPMC_WK_TMR, LPMC_SSTBY);
		wake(LPMC_WK_OSC, LPMC_SSTBY);
		wake(LPMC_WK_RTC_ALM, LPMC_RUN);
		link_rd(LPMC_SEL_STBY, 32'hC000, 32'hFFFF);
		$display("test standby done");
		osc_det <= 1'b1;
		link_op(LPMC_OP_WAIT, 1'b0, 32'h0);
		await_mode(LPMC_SLEEP);
		wake(LPMC_WK_NMI, LPMC_RUN);
		osc_det <= 1'b0;
		$display("test override done");
		link_op(LPMC_OP_WRITE, LPMC_SEL_STBY, 32'h4000);
		link_op(LPMC_OP_WRITE, LPMC_SEL_MSTPA, 32'hA9000010);
		link_op(LPMC_OP_WAIT, 1'b0, 32'h0);
		await_mode(LPMC_ACS);
		check("timer_run", 32'(timer_run), 32'h1);
		check("acs stops", 32'({periph_clk_stop, cpu_stop, flash_stop}), 32'h7);
		check("acs pins", 32'({tpl, rpl, osc_stop, io_hold}), 32'({1'b1, sub_en, 2'b01}));
		wake(LPMC_WK_OSC, LPMC_RUN);
		link_op(LPMC_OP_WAIT, 1'b0, 32'h0);
		await_mode(LPMC_ACS);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("mode", 32'(link.mode), 32'(LPMC_RUN));
		check("module_stop", module_stop, LPMC_MSTPA_RESET);
		$display("test clock stop done");
		complete_run();
	end
endmodule : low_power_mode_controller_tb
